// file: energy_pulse_output.sv
`include "energy_pulse_consts.svh"

module energy_pulse_output #(
    parameter logic [20:0] LOW_CYCLES = 21'(`PULSE_LOW_MS * `CLK_HZ / 1000),
    parameter logic [20:0] SPLIT_CYCLES = 21'(`PULSE_SPLIT_MS * `CLK_HZ / 1000)
)(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire energy_pulse_pkg::lsb_events_t lsb_events,
    input wire logic [23:0] apparent_power,
    input wire logic [23:0] irms_value,
    input wire logic [7:0] high_events,
    output logic pulse_out_a_n,
    output logic pulse_out_b_n,
    output logic energy_irq,
    output logic [15:0] energy_irq_vector,
    output logic apparent_accum_enable
);

    energy_pulse_pkg::pulse_state_t s;
    energy_pulse_pkg::pulse_state_t n;

    logic [31:0] nl_thr;
    logic app_below;
    logic irms_below;
    logic app_ev;
    logic irms_ev;
    logic [1:0] src;
    logic [1:0] fire;
    logic [1:0][15:0] num_e;
    logic [1:0][15:0] den_e;
    logic [1:0][16:0] sum;
    logic [8:0] wdec;
    logic [8:0] rdec;
    logic wr_go;
    logic rd_go;
    logic autoclr;
    logic [7:0] clr_l;
    logic [7:0] clr_m;
    logic [7:0] clr_h;

    function automatic logic [8:0] decode(input logic [11:0] a);
        decode = {a[11:10] == 2'h0, a[9:2]};
    endfunction

    // Zero acts as one, ratio above one clamps
    function automatic logic [15:0] eff_den(input logic [15:0] d);
        eff_den = (d == 16'h0) ? 16'h1 : d;
    endfunction

    function automatic logic [15:0] eff_num(input logic [15:0] nm, input logic [15:0] d);
        logic [15:0] nz;
        nz = (nm == 16'h0) ? 16'h1 : nm;
        eff_num = (nz > eff_den(d)) ? eff_den(d) : nz;
    endfunction

    // Low time from the period just ended
    function automatic logic [20:0] low_len(input logic [20:0] p);
        if (p >= SPLIT_CYCLES)
        begin
            low_len = LOW_CYCLES;
        end
        else if (p[20:1] == 20'h0)
        begin
            low_len = 21'h1;
        end
        else
        begin
            low_len = {1'b0, p[20:1]};
        end
    endfunction

    function automatic logic [7:0] clr_mask(input logic rd_hit, input logic wr_hit,
                                            input logic ac, input logic [7:0] d);
        if (ac && rd_hit)
        begin
            clr_mask = 8'hff;
        end
        else if (!ac && wr_hit)
        begin
            clr_mask = ~d;
        end
        else
        begin
            clr_mask = 8'h0;
        end
    endfunction

    always_comb
    begin
        case (s.nlcfg[1:0])
            2'h1: nl_thr = `NL_FULL_SCALE * `NL_PPM_LVL1 / `PPM_DIV;
            2'h2: nl_thr = `NL_FULL_SCALE * `NL_PPM_LVL2 / `PPM_DIV;
            2'h3: nl_thr = `NL_FULL_SCALE * `NL_PPM_LVL3 / `PPM_DIV;
            default: nl_thr = 32'h0;
        endcase
    end

    assign app_below = (s.nlcfg[1:0] != 2'h0) && ({8'h0, apparent_power} < nl_thr);
    assign irms_below = (s.nlcfg[1:0] != 2'h0) && ({8'h0, irms_value} < nl_thr);
    assign app_ev = lsb_events.apparent && !app_below;
    assign irms_ev = lsb_events.irms && !irms_below;

    generate
        for (genvar c = 0; c < 2; c++)
        begin : g_ch
            assign src[c] = s.cfg2[2*c+1] ? (s.cfg2[`CFG2_RMS_SEL] ? irms_ev : app_ev)
                                          : (s.cfg2[2*c] ? lsb_events.reactive : lsb_events.active);
            assign num_e[c] = eff_num(s.num[c], s.den[c]);
            assign den_e[c] = eff_den(s.den[c]);
            // unity ratio fires on each LSB
            assign sum[c] = {1'b0, s.acc[c]} + {1'b0, num_e[c]};
            assign fire[c] = src[c] && (sum[c] >= {1'b0, den_e[c]});
        end
    endgenerate

    assign wdec = decode(awaddr);
    assign rdec = decode(araddr);
    assign wr_go = (s.state == energy_pulse_pkg::BUS_WACK) && wdec[8];
    assign rd_go = (s.state == energy_pulse_pkg::BUS_RACK) && rdec[8];
    assign autoclr = s.pme[`PME_AUTOCLR];
    assign clr_l = clr_mask(rd_go && rdec[7:0] == `IDX_ST_LOW, wr_go && wdec[7:0] == `IDX_ST_LOW && wstrb[0],
                            autoclr, wdata[7:0]);
    assign clr_m = clr_mask(rd_go && rdec[7:0] == `IDX_ST_MID, wr_go && wdec[7:0] == `IDX_ST_MID && wstrb[0],
                            autoclr, wdata[7:0]);
    assign clr_h = clr_mask(rd_go && rdec[7:0] == `IDX_ST_HIGH, wr_go && wdec[7:0] == `IDX_ST_HIGH && wstrb[0],
                            autoclr, wdata[7:0]);

    always_comb
    begin
        n = s;
        n.awready = 1'b0;
        n.wready = 1'b0;
        n.arready = 1'b0;
        case (s.state)
            energy_pulse_pkg::BUS_IDLE:
            begin
                if (awvalid && wvalid)
                begin
                    n.awready = 1'b1;
                    n.wready = 1'b1;
                    n.state = energy_pulse_pkg::BUS_WACK;
                end
                else if (arvalid)
                begin
                    n.arready = 1'b1;
                    n.state = energy_pulse_pkg::BUS_RACK;
                end
            end
            energy_pulse_pkg::BUS_WACK:
            begin
                n.bvalid = 1'b1;
                n.bresp = `RESP_OKAY;
                n.state = energy_pulse_pkg::BUS_WRESP;
                if (!wdec[8])
                begin
                    n.bresp = `RESP_SLVERR;
                end
                else if (wdec[7:0] == `IDX_CFG_ONE)
                begin
                    n.cfg1 = wstrb[0] ? wdata[7:0] : s.cfg1;
                end
                else if (wdec[7:0] == `IDX_CFG_TWO)
                begin
                    n.cfg2 = wstrb[0] ? wdata[7:0] : s.cfg2;
                end
                else if (wdec[7:0] == `IDX_NL_CFG)
                begin
                    n.nlcfg = wstrb[0] ? wdata[7:0] : s.nlcfg;
                end
                else if (wdec[7:0] == `IDX_EN_LOW)
                begin
                    n.en_l = wstrb[0] ? wdata[7:0] : s.en_l;
                end
                else if (wdec[7:0] == `IDX_EN_MID)
                begin
                    n.en_m = wstrb[0] ? wdata[7:0] : s.en_m;
                end
                else if (wdec[7:0] == `IDX_EN_HIGH)
                begin
                    n.en_h = wstrb[0] ? wdata[7:0] : s.en_h;
                end
                else if (wdec[7:0] == `IDX_PME)
                begin
                    n.pme = wstrb[0] ? wdata[7:0] : s.pme;
                end
                else if (wdec[7:0] == `IDX_NUM_A || wdec[7:0] == `IDX_NUM_B)
                begin
                    n.num[wdec[1]] = {wstrb[1] ? wdata[15:8] : s.num[wdec[1]][15:8],
                                      wstrb[0] ? wdata[7:0] : s.num[wdec[1]][7:0]};
                end
                else if (wdec[7:0] == `IDX_DEN_A || wdec[7:0] == `IDX_DEN_B)
                begin
                    n.den[wdec[1]] = {wstrb[1] ? wdata[15:8] : s.den[wdec[1]][15:8],
                                      wstrb[0] ? wdata[7:0] : s.den[wdec[1]][7:0]};
                end
                else if (wdec[7:0] != `IDX_ST_LOW && wdec[7:0] != `IDX_ST_MID && wdec[7:0] != `IDX_ST_HIGH)
                begin
                    n.bresp = `RESP_SLVERR;
                end
            end
            energy_pulse_pkg::BUS_WRESP:
            begin
                if (bready)
                begin
                    n.bvalid = 1'b0;
                    n.state = energy_pulse_pkg::BUS_IDLE;
                end
            end
            energy_pulse_pkg::BUS_RACK:
            begin
                n.rvalid = 1'b1;
                n.rresp = `RESP_OKAY;
                n.rdata = 32'h0;
                n.state = energy_pulse_pkg::BUS_RRESP;
                if (!rdec[8])
                begin
                    n.rresp = `RESP_SLVERR;
                end
                else if (rdec[7:0] == `IDX_CFG_ONE)
                begin
                    n.rdata[7:0] = s.cfg1;
                end
                else if (rdec[7:0] == `IDX_CFG_TWO)
                begin
                    n.rdata[7:0] = s.cfg2;
                end
                else if (rdec[7:0] == `IDX_NL_CFG)
                begin
                    n.rdata[7:0] = s.nlcfg;
                end
                else if (rdec[7:0] == `IDX_EN_LOW)
                begin
                    n.rdata[7:0] = s.en_l;
                end
                else if (rdec[7:0] == `IDX_EN_MID)
                begin
                    n.rdata[7:0] = s.en_m;
                end
                else if (rdec[7:0] == `IDX_EN_HIGH)
                begin
                    n.rdata[7:0] = s.en_h;
                end
                else if (rdec[7:0] == `IDX_ST_LOW)
                begin
                    n.rdata[7:0] = s.st_l;
                end
                else if (rdec[7:0] == `IDX_ST_MID)
                begin
                    n.rdata[7:0] = s.st_m;
                end
                else if (rdec[7:0] == `IDX_ST_HIGH)
                begin
                    n.rdata[7:0] = s.st_h;
                end
                else if (rdec[7:0] == `IDX_PME)
                begin
                    n.rdata[7:0] = s.pme;
                end
                else if (rdec[7:0] == `IDX_NUM_A || rdec[7:0] == `IDX_NUM_B)
                begin
                    n.rdata[15:0] = s.num[rdec[1]];
                end
                else if (rdec[7:0] == `IDX_DEN_A || rdec[7:0] == `IDX_DEN_B)
                begin
                    n.rdata[15:0] = s.den[rdec[1]];
                end
                else
                begin
                    n.rresp = `RESP_SLVERR;
                end
            end
            energy_pulse_pkg::BUS_RRESP:
            begin
                if (rready)
                begin
                    n.rvalid = 1'b0;
                    n.state = energy_pulse_pkg::BUS_IDLE;
                end
            end
            default:
            begin
                n.state = energy_pulse_pkg::BUS_IDLE;
            end
        endcase

        for (int c = 0; c < 2; c++)
        begin
            if (fire[c])
            begin
                n.acc[c] = sum[c][15:0] - den_e[c];
            end
            else if (src[c])
            begin
                n.acc[c] = sum[c][15:0];
            end
            if (fire[c])
            begin
                n.period[c] = 21'h1;
                n.lowcnt[c] = low_len(s.period[c]);
            end
            else
            begin
                if (s.period[c] < SPLIT_CYCLES)
                begin
                    n.period[c] = s.period[c] + 21'h1;
                end
                if (s.lowcnt[c] != 21'h0)
                begin
                    n.lowcnt[c] = s.lowcnt[c] - 21'h1;
                end
            end
            n.pout[c] = s.cfg1[c] || (n.lowcnt[c] == 21'h0);
        end

        // Set wins over a same-cycle clear
        // no-load flag, level driven
        n.st_l = (s.st_l & ~clr_l) | {7'h0, app_below};
        n.st_m = (s.st_m & ~clr_m) | {6'h0, fire};
        n.st_h = (s.st_h & ~clr_h) | high_events;
        // held while a cause stays set
        n.irq = |{n.st_l & n.en_l, n.st_m & n.en_m, n.st_h & n.en_h};
        n.accum_en = !app_below;
        n.vector = `IRQ_VECTOR;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s <= '0;
            s.state <= energy_pulse_pkg::BUS_IDLE;
            s.pout <= 2'h3;
            s.accum_en <= 1'b1;
            s.period <= {SPLIT_CYCLES, SPLIT_CYCLES};
            s.vector <= `IRQ_VECTOR;
        end
        else
        begin
            s <= n;
        end
    end

    assign awready = s.awready;
    assign wready = s.wready;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = s.arready;
    assign rvalid = s.rvalid;
    assign rresp = s.rresp;
    assign rdata = s.rdata;
    assign pulse_out_a_n = s.pout[0];
    assign pulse_out_b_n = s.pout[1];
    assign energy_irq = s.irq;
    assign energy_irq_vector = s.vector;
    assign apparent_accum_enable = s.accum_en;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_fire_a;
        fire[0] && !s.cfg1[0];
    endsequence

    sequence s_rd_mid_auto;
        rd_go && rdec[7:0] == `IDX_ST_MID && autoclr && fire == 2'h0;
    endsequence

    sequence s_w1_mid;
        wr_go && wdec[7:0] == `IDX_ST_MID && wstrb[0] && !autoclr && wdata[0] && s.st_m[0];
    endsequence

    a_noload_accum: assert property (app_below |=> !apparent_accum_enable)
        else $error("apparent accumulation not stopped");
    a_noload_flag: assert property (app_below |=> s.st_l[0] ##1 s.st_l[0] || !app_below)
        else $error("no-load flag missing");
    a_noload_off: assert property (s.nlcfg[1:0] == 2'h0 && lsb_events.apparent |-> app_ev)
        else $error("disabled no-load still gating");
    a_disable_out: assert property (s.cfg1[0] |=> pulse_out_a_n)
        else $error("disabled output went low");
    a_pulse_start: assert property (s_fire_a |=> !pulse_out_a_n && s.st_m[0])
        else $error("pulse or flag missing");
    a_long_low: assert property (fire[0] && s.period[0] == SPLIT_CYCLES |=> s.lowcnt[0] == LOW_CYCLES)
        else $error("long-period low time wrong");
    a_half_duty: assert property (fire[0] && s.period[0] < SPLIT_CYCLES && s.period[0] > 21'h3
                                  |=> s.lowcnt[0] == {1'b0, $past(s.period[0][20:1])})
        else $error("short-period duty wrong");
    a_ratio_clamp: assert property (s.num[0] > s.den[0] && src[0] |-> fire[0])
        else $error("ratio not clamped");
    a_irq_gate: assert property ((s.st_m & s.en_m) == 8'h0 && (s.st_l & s.en_l) == 8'h0
                                 && (s.st_h & s.en_h) == 8'h0 |-> !energy_irq)
        else $error("interrupt without enabled cause");
    a_irq_hold: assert property ((s.st_m & s.en_m) != 8'h0 && clr_m == 8'h0 && !wr_go
                                 ##1 clr_m == 8'h0 && !wr_go |-> energy_irq ##1 energy_irq)
        else $error("interrupt dropped early");
    a_auto_clear: assert property (s_rd_mid_auto |=> s.st_m == 8'h0)
        else $error("status not cleared by read");
    a_w1_keeps: assert property (s_w1_mid |=> s.st_m[0])
        else $error("writing one cleared status");

endmodule

// file: energy_pulse_consts.svh
`ifndef ENERGY_PULSE_CONSTS_SVH
`define ENERGY_PULSE_CONSTS_SVH

`define CLK_HZ 10000000
`define PULSE_LOW_MS 90
`define PULSE_SPLIT_MS 180

`define IDX_CFG_ONE 8'h0b
`define IDX_CFG_TWO 8'h0c
`define IDX_NL_CFG 8'h0e
`define IDX_EN_LOW 8'hd9
`define IDX_EN_MID 8'hda
`define IDX_EN_HIGH 8'hdb
`define IDX_ST_LOW 8'hdc
`define IDX_ST_MID 8'hdd
`define IDX_ST_HIGH 8'hde
`define IDX_PME 8'hec
`define IDX_NUM_A 8'h40
`define IDX_DEN_A 8'h41
`define IDX_NUM_B 8'h42
`define IDX_DEN_B 8'h43

`define CFG2_RMS_SEL 4
`define PME_AUTOCLR 6
`define NL_FULL_SCALE 32'h001a36e2
`define NL_PPM_LVL1 32'h0000012c
`define NL_PPM_LVL2 32'h00000096
`define NL_PPM_LVL3 32'h0000004b
`define PPM_DIV 32'h000f4240
`define IRQ_VECTOR 16'h004b
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: energy_pulse_pkg.sv
package energy_pulse_pkg;

    typedef enum logic [4:0] {
        BUS_IDLE = 5'h01,
        BUS_WACK = 5'h02,
        BUS_WRESP = 5'h04,
        BUS_RACK = 5'h08,
        BUS_RRESP = 5'h10
    } bus_state_t;

    typedef struct packed {
        logic active;
        logic reactive;
        logic apparent;
        logic irms;
    } lsb_events_t;

    typedef struct packed {
        bus_state_t state;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [7:0] cfg1;
        logic [7:0] cfg2;
        logic [7:0] nlcfg;
        logic [7:0] en_l;
        logic [7:0] en_m;
        logic [7:0] en_h;
        logic [7:0] st_l;
        logic [7:0] st_m;
        logic [7:0] st_h;
        logic [7:0] pme;
        logic [1:0][15:0] num;
        logic [1:0][15:0] den;
        logic [1:0][15:0] acc;
        logic [1:0][20:0] period;
        logic [1:0][20:0] lowcnt;
        logic [1:0] pout;
        logic irq;
        logic accum_en;
        logic [15:0] vector;
    } pulse_state_t;

endpackage

// file: pulse_meter.sv
module pulse_meter (
    input wire logic aclk,
    input wire logic pin_n,
    output int falls,
    output int low_len
);
    timeunit 1ns;
    timeprecision 1ns;
    int run = 0;
    logic prev = 1'b1;
    initial falls = 0;
    initial low_len = 0;
    always @(posedge aclk)
    begin
        if (prev === 1'b1 && pin_n === 1'b0)
        begin
            falls <= falls + 1;
            run <= 1;
        end
        else if (pin_n === 1'b0)
            run <= run + 1;
        else if (prev === 1'b0)
            low_len <= run;
        prev <= pin_n;
    end
endmodule

// file: energy_pulse_output_tb_top.sv
`include "energy_pulse_consts.svh"

module energy_pulse_output_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LOWC = 20;
    localparam int PER = 10;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, pa_n, pb_n, irq, acc_en;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] vec;
    energy_pulse_pkg::lsb_events_t ev_in = 4'h0;
    logic [23:0] ap = 24'h0fffff;
    logic [23:0] ir = 24'h0fffff;
    logic [7:0] hi = 8'h00;
    int bad_count = 0, checks_done = 0, fa, fb, la, lb;

    always #50 aclk = ~aclk;

    energy_pulse_output #(.LOW_CYCLES(21'(LOWC)), .SPLIT_CYCLES(21'(2 * LOWC))) uut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .lsb_events(ev_in),
        .apparent_power(ap), .irms_value(ir), .high_events(hi), .pulse_out_a_n(pa_n),
        .pulse_out_b_n(pb_n), .energy_irq(irq), .energy_irq_vector(vec), .apparent_accum_enable(acc_en)
    );
    pulse_meter ma (.aclk(aclk), .pin_n(pa_n), .falls(fa), .low_len(la));
    pulse_meter mb (.aclk(aclk), .pin_n(pb_n), .falls(fb), .low_len(lb));

    task automatic end_of_test();
        if (bad_count == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e)
        begin
            $display("Error %s expected %h seen %h", nm, e, s);
            bad_count++;
        end
    endtask

    // Bounded wait; a hang ends the run
    task automatic wt(ref logic s);
        int n;
        n = 0;
        @(posedge aclk);
        while (s !== 1'b1)
        begin
            n++;
            if (n > 100)
            begin
                bad_count++;
                end_of_test();
            end
            @(posedge aclk);
        end
    endtask

    task automatic wr(input logic [7:0] i, input logic [31:0] d, input logic [1:0] er);
        awaddr <= {2'h0, i, 2'h0};
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        wt(awready);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        wt(bvalid);
        bready <= 1'b0;
        chk("bresp", 32'(er), 32'(bresp));
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] i, input logic [31:0] e, input logic [1:0] er);
        araddr <= {2'h0, i, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        wt(arready);
        arvalid <= 1'b0;
        wt(rvalid);
        rready <= 1'b0;
        chk("rdata", e, rdata);
        chk("rresp", 32'(er), 32'(rresp));
        @(posedge aclk);
    endtask

    task automatic ev(input logic [3:0] b, input int g);
        ev_in <= energy_pulse_pkg::lsb_events_t'(b);
        @(posedge aclk);
        ev_in <= 4'h0;
        repeat (g - 1) @(posedge aclk);
    endtask

    task automatic t_reset();
        logic [7:0] idx [9] = '{`IDX_CFG_ONE, `IDX_CFG_TWO, `IDX_NL_CFG, `IDX_EN_LOW, `IDX_EN_MID,
            `IDX_EN_HIGH, `IDX_ST_LOW, `IDX_ST_MID, `IDX_PME};
        chk("pulse_a", 1, 32'(pa_n));
        chk("irq", 0, 32'(irq));
        chk("vector", 32'(`IRQ_VECTOR), 32'(vec));
        foreach (idx[k])
            rd(idx[k], 0, `RESP_OKAY);
        rd(8'h01, 0, `RESP_SLVERR);
        wr(8'h01, 32'h000000ff, `RESP_SLVERR);
    endtask

    task automatic t_ratio();
        int a;
        wr(`IDX_NUM_A, 32'h1234ffff, `RESP_OKAY);
        rd(`IDX_NUM_A, 32'h0000ffff, `RESP_OKAY);
        wr(`IDX_NUM_A, 1, `RESP_OKAY);
        wr(`IDX_DEN_A, 3, `RESP_OKAY);
        a = fa;
        repeat (6) ev(4'h8, 50);
        chk("falls_a", a + 2, fa);
        chk("low_a", LOWC, la);
        wr(`IDX_NUM_A, 0, `RESP_OKAY);
        wr(`IDX_DEN_A, 0, `RESP_OKAY);
        a = fa;
        repeat (3) ev(4'h8, 50);
        chk("falls_a", a + 3, fa);
        wr(`IDX_NUM_A, 5, `RESP_OKAY);
        wr(`IDX_DEN_A, 2, `RESP_OKAY);
        a = fa;
        repeat (3) ev(4'h8, 50);
        chk("falls_a", a + 3, fa);
        repeat (4) ev(4'h8, PER);
        repeat (30) @(posedge aclk);
        chk("low_a", PER / 2, la);
    endtask

    task automatic t_disable();
        int a, b;
        a = fa;
        b = fb;
        wr(`IDX_CFG_ONE, 1, `RESP_OKAY);
        ev(4'h8, 50);
        chk("falls_a", a, fa);
        chk("falls_b", b + 1, fb);
        wr(`IDX_CFG_ONE, 0, `RESP_OKAY);
    endtask

    task automatic t_status();
        rd(`IDX_ST_MID, 3, `RESP_OKAY);
        chk("irq", 0, 32'(irq));
        wr(`IDX_EN_MID, 1, `RESP_OKAY);
        chk("irq", 1, 32'(irq));
        wr(`IDX_ST_MID, 1, `RESP_OKAY);
        rd(`IDX_ST_MID, 1, `RESP_OKAY);
        chk("irq", 1, 32'(irq));
        wr(`IDX_ST_MID, 2, `RESP_OKAY);
        rd(`IDX_ST_MID, 0, `RESP_OKAY);
        chk("irq", 0, 32'(irq));
        wr(`IDX_ST_MID, 0, `RESP_OKAY);
        wr(`IDX_EN_MID, 0, `RESP_OKAY);
        // Third status register, set from outside
        hi <= 8'h04;
        @(posedge aclk);
        hi <= 8'h00;
        rd(`IDX_ST_HIGH, 4, `RESP_OKAY);
        chk("irq", 0, 32'(irq));
        wr(`IDX_EN_HIGH, 4, `RESP_OKAY);
        chk("irq", 1, 32'(irq));
        wr(`IDX_ST_HIGH, 0, `RESP_OKAY);
        chk("irq", 0, 32'(irq));
        wr(`IDX_EN_HIGH, 0, `RESP_OKAY);
    endtask

    task automatic t_source();
        int a, b;
        for (int s = 0; s < 4; s++)
        begin
            wr(`IDX_CFG_TWO, 32'(s * 4 + (s == 3) * 16), `RESP_OKAY);
            for (int e = 0; e < 4; e++)
            begin
                b = fb;
                ev(4'(1 << e), 50);
                chk("falls_b", b + int'(e == 3 - s), fb);
            end
        end
        // Both outputs on 1x follow the one shared select
        wr(`IDX_CFG_TWO, 32'h1e, `RESP_OKAY);
        a = fa;
        b = fb;
        ev(4'h1, 50);
        ev(4'h2, 50);
        chk("falls_a", a + 1, fa);
        chk("falls_b", b + 1, fb);
    endtask

    task automatic t_noload();
        int thr [4];
        int a;
        thr = '{0, `NL_FULL_SCALE * `NL_PPM_LVL1 / `PPM_DIV, `NL_FULL_SCALE * `NL_PPM_LVL2 / `PPM_DIV,
            `NL_FULL_SCALE * `NL_PPM_LVL3 / `PPM_DIV};
        // Off by one either side, clear of rounding
        for (int k = 0; k < 4; k++)
        begin
            wr(`IDX_NL_CFG, 32'(k), `RESP_OKAY);
            ap <= (k == 0) ? 24'h000000 : 24'(thr[k] - 1);
            repeat (3) @(posedge aclk);
            chk("accum_en", 32'(k == 0), 32'(acc_en));
            ap <= 24'(thr[k] + 1);
            repeat (3) @(posedge aclk);
            chk("accum_en", 1, 32'(acc_en));
        end
        wr(`IDX_EN_LOW, 1, `RESP_OKAY);
        chk("irq", 1, 32'(irq));
        wr(`IDX_CFG_TWO, 2, `RESP_OKAY);
        a = fa;
        ap <= 24'h000000;
        ev(4'h2, 50);
        chk("falls_a", a, fa);
        ap <= 24'h0fffff;
        ev(4'h2, 50);
        chk("falls_a", a + 1, fa);
        wr(`IDX_CFG_TWO, 32'h13, `RESP_OKAY);
        ir <= 24'h000000;
        ev(4'h1, 50);
        chk("falls_a", a + 1, fa);
        ir <= 24'h0fffff;
        ev(4'h1, 50);
        chk("falls_a", a + 2, fa);
        chk("irq", 1, 32'(irq));
        wr(`IDX_PME, 32'h40, `RESP_OKAY);
        rd(`IDX_ST_LOW, 1, `RESP_OKAY);
        rd(`IDX_ST_LOW, 0, `RESP_OKAY);
        rd(`IDX_ST_MID, 3, `RESP_OKAY);
        rd(`IDX_ST_MID, 0, `RESP_OKAY);
        chk("irq", 0, 32'(irq));
    endtask

    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_ratio();
        t_disable();
        t_status();
        t_source();
        t_noload();
        end_of_test();
    end
endmodule
